// [verilog/usd_consts.svh]
// timing and encoding constants for the start-detect and multidrop receiver
`ifndef USD_CONSTS_SVH
`define USD_CONSTS_SVH
`define USD_CLK_MHZ 40
`define USD_SIZE_NINE 3'h7
`define USD_FLAG_ADDR 1'h1
`define USD_DATA_W 9
`define USD_FIFO_DEPTH 16
`define USD_OSC_START_NS 1000
`define USD_OSC_START_CYC ((`USD_OSC_START_NS * `USD_CLK_MHZ + 999) / 1000)
`endif

// [verilog/usd_pkg.sv]
// types shared by the start-detect and multidrop receiver
package usd_pkg;
  typedef struct packed {
    logic [8:0] data;
    logic frame_flag;
  } usd_frame_type;
  typedef enum logic [1:0] {
    USD_AWAKE,
    USD_ASLEEP,
    USD_OSC_START,
    USD_RECEIVING
  } usd_state_type;
endpackage

// [verilog/usd_fifo.sv]
// synchronous fifo with valid and ready on both sides
module usd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;
  assign in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data_i;
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule // usd_fifo

// [verilog/usd_rx_ext.sv]
// start-frame detector and multidrop address filter on the receive path
`include "usd_consts.svh"
module usd_rx_ext #(
  parameter int OSC_START_CYC = `USD_OSC_START_CYC,
  parameter int FIFO_DEPTH = `USD_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serial_receive_line_i,
  input wire logic deep_sleep_i,
  input wire logic start_frame_detect_enable_i,
  input wire logic receive_start_irq_enable_i,
  input wire logic synchronous_mode_i,
  input wire logic multidrop_filter_enable_i,
  input wire logic [2:0] character_size_code_i,
  input wire logic [8:0] frame_data_i,
  input wire logic first_stop_bit_i,
  input wire logic frame_done_i,
  output logic frame_taken_o,
  output logic oscillator_enable_o,
  output logic transceiver_clock_enable_o,
  output logic system_clock_enable_o,
  output logic receive_start_irq_o,
  output logic wake_request_o,
  output logic [2:0] tx_character_size_o,
  output logic [8:0] serial_data_register_o,
  output logic received_ninth_bit_o,
  output logic receive_complete_flag_o,
  input wire logic serial_data_read_i
);
  initial
  begin
    // start counter is 16 bits wide
    if (OSC_START_CYC < 1 || OSC_START_CYC > 65536)
      $error("oscillator start count must lie between one and 65536");
  end

  usd_pkg::usd_state_type state_q;
  logic line_q;
  logic [15:0] osc_cnt_q;
  logic irq_q;
  logic fall;
  logic is_addr;
  logic keep;
  logic fifo_ready;
  logic fifo_valid;
  usd_pkg::usd_frame_type in_frame;
  usd_pkg::usd_frame_type out_frame;

  function automatic logic frame_flag(input logic [2:0] size, input logic [8:0] d,
                                      input logic stop);
    frame_flag = (size == `USD_SIZE_NINE) ? d[8] : stop;
  endfunction

  // previous line level kept so a falling edge can be seen
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      line_q <= 1'b1;
    else
      line_q <= serial_receive_line_i;
  end
  // detector is mode-agnostic: same edge in async and sync mode
  assign fall = line_q && !serial_receive_line_i && start_frame_detect_enable_i;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= usd_pkg::USD_AWAKE;
      osc_cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        usd_pkg::USD_AWAKE:
          if (deep_sleep_i)
            state_q <= usd_pkg::USD_ASLEEP;
        usd_pkg::USD_ASLEEP:
          if (!deep_sleep_i)
            state_q <= usd_pkg::USD_AWAKE;
          else if (fall)
          begin
            state_q <= usd_pkg::USD_OSC_START;
            osc_cnt_q <= 16'(OSC_START_CYC - 1);
          end
        usd_pkg::USD_OSC_START:
          if (osc_cnt_q == '0)
            state_q <= usd_pkg::USD_RECEIVING;
          else
            osc_cnt_q <= osc_cnt_q - 1'b1;
        usd_pkg::USD_RECEIVING:
          if (!deep_sleep_i)
            state_q <= usd_pkg::USD_AWAKE;
          else if (frame_done_i)
            state_q <= usd_pkg::USD_ASLEEP; // frame finished: back to sleep
        default:
          state_q <= usd_pkg::USD_AWAKE;
      endcase
    end
  end

  // deep sleep keeps the oscillator off unless a detected frame is in flight
  assign oscillator_enable_o = (state_q == usd_pkg::USD_AWAKE) ||
                               (state_q == usd_pkg::USD_OSC_START) ||
                               (state_q == usd_pkg::USD_RECEIVING);
  assign transceiver_clock_enable_o = (state_q == usd_pkg::USD_AWAKE) ||
                                      (state_q == usd_pkg::USD_RECEIVING);
  assign system_clock_enable_o = (state_q == usd_pkg::USD_AWAKE) ||
                                 (state_q != usd_pkg::USD_ASLEEP && irq_q);

  // start irq is a level until the device is awake again
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_q <= 1'b0;
    else if (state_q == usd_pkg::USD_ASLEEP && fall && receive_start_irq_enable_i)
      irq_q <= 1'b1;
    else if (state_q == usd_pkg::USD_AWAKE)
      irq_q <= 1'b0;
  end
  assign receive_start_irq_o = irq_q;
  assign wake_request_o = irq_q || receive_complete_flag_o;

  // transmit path shares size only; filter never touches it
  assign tx_character_size_o = character_size_code_i;

  assign is_addr = frame_flag(character_size_code_i, frame_data_i, first_stop_bit_i) ==
                   `USD_FLAG_ADDR;
  assign keep = !multidrop_filter_enable_i || is_addr;
  assign in_frame.data = frame_data_i;
  assign in_frame.frame_flag = is_addr;
  // a full buffer stalls the framer through frame_taken_o
  assign frame_taken_o = frame_done_i && (!keep || fifo_ready);

  usd_fifo #(
    .WIDTH(`USD_DATA_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(in_frame),
    .in_valid_i(frame_done_i && keep),
    .in_ready_o(fifo_ready),
    .out_data_o(out_frame),
    .out_valid_o(fifo_valid),
    .out_ready_i(serial_data_read_i)
  );

  assign receive_complete_flag_o = fifo_valid;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      serial_data_register_o <= '0;
      received_ninth_bit_o <= 1'b0;
    end
    else
    begin
      serial_data_register_o <= out_frame.data;
      received_ninth_bit_o <= out_frame.data[8];
    end
  end
endmodule // usd_rx_ext

// [tb/usd_rx_ext_asserts.sv]
// port checker for the start-detect and multidrop receiver
module usd_rx_ext_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serial_receive_line_i,
  input wire logic deep_sleep_i,
  input wire logic start_frame_detect_enable_i,
  input wire logic receive_start_irq_enable_i,
  input wire logic multidrop_filter_enable_i,
  input wire logic [2:0] character_size_code_i,
  input wire logic [8:0] frame_data_i,
  input wire logic first_stop_bit_i,
  input wire logic frame_done_i,
  input wire logic frame_taken_o,
  input wire logic oscillator_enable_o,
  input wire logic receive_start_irq_o,
  input wire logic wake_request_o,
  input wire logic [2:0] tx_character_size_o,
  input wire logic receive_complete_flag_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic fl, tk, wk;
  assign fl = (character_size_code_i == 3'h7) ? frame_data_i[8] : first_stop_bit_i;
  assign tk = frame_done_i && frame_taken_o && !receive_complete_flag_o;
  assign wk = deep_sleep_i && !oscillator_enable_o && start_frame_detect_enable_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  size_share_a:
    assert property (tx_character_size_o == character_size_code_i) else $error("size");
  wake_merge_a:
    assert property (wake_request_o == (receive_start_irq_o || receive_complete_flag_o))
      else $error("wake");
  data_drop_a:
    assert property (tk && multidrop_filter_enable_i && !fl |=> !receive_complete_flag_o)
      else $error("drop");
  addr_keep_a:
    assert property (tk && fl |=> receive_complete_flag_o) else $error("addr");
  open_keep_a:
    assert property (tk && !multidrop_filter_enable_i |=> receive_complete_flag_o)
      else $error("open");
  dark_sleep_a:
    assert property (deep_sleep_i && !start_frame_detect_enable_i && !oscillator_enable_o
      |=> !oscillator_enable_o) else $error("dark");
  osc_wake_a:
    assert property (wk && $fell(serial_receive_line_i) |-> ##[1:2] oscillator_enable_o)
      else $error("osc");
  irq_wake_a:
    assert property (wk && receive_start_irq_enable_i && $fell(serial_receive_line_i)
      |-> ##[1:2] receive_start_irq_o) else $error("irq");
endmodule // usd_rx_ext_asserts
bind usd_rx_ext usd_rx_ext_asserts usd_rx_ext_asserts_i (.*);

// [tb/usd_remote_tx.sv]
// remote sender model facing the receive path
module usd_remote_tx (
  input wire logic clk_i,
  input wire logic taken_i,
  output logic line_o,
  output logic done_o,
  output logic [8:0] data_o,
  output logic stop_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    line_o = 1'h1;
    done_o = 1'h0;
    data_o = 9'h000;
    stop_o = 1'h0;
  end
  // long low start so the oscillator can come up
  // bit pace far below every async, sync and error limit
  task automatic start_bit(input int n);
    line_o = 1'h0;
    repeat (n) @(posedge clk_i);
    #2 line_o = 1'h1;
  endtask
  // flag rides on bit 8 or on the first of two stop bits
  task automatic send(input logic [8:0] d, input logic s, output logic ok);
    start_bit(2);
    data_o = d;
    stop_o = s;
    done_o = 1'h1;
    ok = 1'h0;
    repeat (20)
    begin
      @(posedge clk_i);
      ok = taken_i;
      if (ok) break;
    end
    #2 done_o = 1'h0;
    data_o = ~d;
    stop_o = ~s;
  endtask
endmodule // usd_remote_tx

// [tb/testbench.sv]
// testbench for the start-detect and multidrop receiver
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic sl = 1'h0, sf = 1'h0, si = 1'h0, sy = 1'h0, mp = 1'h0, rd = 1'h0;
  logic [2:0] sz = 3'h7;
  logic ln, dn, st, tk, ok, osc, xck, sck, irq, wk, rcf;
  logic [8:0] dt, sdr;
  logic n9;
  int error_cnt = 0;
  int num_checks = 0;
  always #12.5 clk_i = ~clk_i;
  usd_rx_ext #(.OSC_START_CYC(3)) usd_rx_ext_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .serial_receive_line_i(ln), .deep_sleep_i(sl), .start_frame_detect_enable_i(sf),
    .receive_start_irq_enable_i(si), .synchronous_mode_i(sy),
    .multidrop_filter_enable_i(mp), .character_size_code_i(sz), .frame_data_i(dt),
    .first_stop_bit_i(st), .frame_done_i(dn), .frame_taken_o(tk),
    .oscillator_enable_o(osc), .transceiver_clock_enable_o(xck),
    .system_clock_enable_o(sck), .receive_start_irq_o(irq), .wake_request_o(wk),
    .tx_character_size_o(), .serial_data_register_o(sdr), .received_ninth_bit_o(n9),
    .receive_complete_flag_o(rcf), .serial_data_read_i(rd));
  usd_remote_tx usd_remote_tx_i (.clk_i(clk_i), .taken_i(tk), .line_o(ln), .done_o(dn),
    .data_o(dt), .stop_o(st));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic rx(input logic [8:0] d, input logic s, input logic [9:0] exp);
    usd_remote_tx_i.send(d, s, ok);
    tick(2);
    chk({rcf, sdr & {9{rcf}}}, exp);
    chk(10'(n9 & rcf), 10'(exp[8] & exp[9]));
    rd = rcf;
    tick(1);
    rd = 1'h0;
  endtask
  task automatic t_filter;
    mp = 1'h1;
    rx(9'h055, 1'h1, 10'h000);
    rx(9'h1a5, 1'h0, 10'h3a5);
    mp = 1'h0;
    rx(9'h033, 1'h0, 10'h233);
    sz = 3'h3;
    mp = 1'h1;
    rx(9'h1ff, 1'h0, 10'h000);
    rx(9'h012, 1'h1, 10'h212);
  endtask
  task automatic t_fifo;
    mp = 1'h0;
    for (int i = 0; i < 17; i++)
    begin
      usd_remote_tx_i.send(9'(i), 1'h0, ok);
      chk(10'(ok), 10'(i < 16));
    end
    // drain without sending, so nothing is left behind for later scenarios
    for (int i = 0; i < 16; i++)
    begin
      chk({rcf, sdr}, {1'h1, 9'(i)});
      rd = 1'h1;
      tick(1);
      rd = 1'h0;
      tick(1);
    end
    chk(10'(rcf), 10'h0);
  endtask
  task automatic t_sleep;
    sl = 1'h1;
    tick(2);
    usd_remote_tx_i.start_bit(3);
    chk(10'(osc), 10'h0);
    sf = 1'h1;
    // line must be seen high for one edge, or no falling edge exists
    tick(1);
    usd_remote_tx_i.start_bit(6);
    chk({osc, xck, irq, sck}, 10'hc);
    rx(9'h0aa, 1'h1, 10'h2aa);
    sl = 1'h0;
    tick(2);
    sl = 1'h1;
    si = 1'h1;
    sy = 1'h1;
    tick(2);
    usd_remote_tx_i.start_bit(1);
    tick(1);
    chk({osc, irq, wk}, 10'h7);
    sl = 1'h0;
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    tick(2);
    chk({osc, irq, rcf}, 10'h4);
    rst_n_i = 1'h1;
    t_filter();
    t_fifo();
    t_sleep();
    end_of_test();
  end
  initial
  begin
    #300000;
    error_cnt++;
    end_of_test();
  end
endmodule // testbench
